// ==== verilog/rstpin_top.sv ====
// Power-on reset pin handling: output safing and self-configuration start
module rstpin_top (
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        CE,
	input  wire logic        POWER_ON_RESET_N,
	input  wire logic        FAST_PARK_REQUEST_N,
	input  wire logic [19:0] CORE_GPIO_OUT,
	input  wire logic [19:0] CORE_GPIO_OE,
	input  wire logic        CORE_FLASH_CLK,
	input  wire logic        CORE_FLASH_OUT,
	input  wire logic        CORE_FLASH_SEL0_N,
	input  wire logic        CORE_FLASH_SEL1_N,
	input  wire logic        CORE_LIGHT_SEL0,
	input  wire logic        CORE_LIGHT_SEL1,
	input  wire logic        CORE_MIRROR_EN_N,
	output logic             FLASH_SERIAL_CLOCK,
	output logic             FLASH_SERIAL_OUT,
	output logic             FLASH_SELECT_0_N,
	output logic             FLASH_SELECT_1_N,
	output logic             FLASH_OE,
	output logic [19:0]      GPIO_OUT,
	output logic [19:0]      GPIO_OE,
	output logic             LIGHT_SOURCE_SELECT_0,
	output logic             LIGHT_SOURCE_SELECT_1,
	output logic             MIRROR_ARRAY_ENABLE_RESET_N,
	output logic             CONFIG_START,
	output logic             CONFIG_BUSY,
	output logic             CONFIG_DONE,
	output logic             PARK_ACTIVE
);
	// ==================================================================
	// Synchronisers
	logic                    por_s1_q;
	logic                    por_s2_q;
	logic                    por_s3_q;
	logic                    park_s1_q;
	logic                    park_s2_q;
	logic                    release_edge;
	rstpin_pkg::rstpin_state_e state_q;
	rstpin_pkg::rstpin_state_e state_d;
	logic [7:0]              cnt_q;
	rstpin_pkg::rstpin_pins_s pins_q;
	rstpin_pkg::rstpin_pins_s pins_d;
	logic                    park_active_q;
	logic                    busy_q;
	logic                    done_q;

	// ==================================================================
	// State decoding
	// One decoder per state keeps the pins and status in step
	function automatic logic f_held(input rstpin_pkg::rstpin_state_e s);
		return (s == rstpin_pkg::RSTPIN_HELD);
	endfunction : f_held

	function automatic logic f_config(input rstpin_pkg::rstpin_state_e s);
		return (s == rstpin_pkg::RSTPIN_CONFIG);
	endfunction : f_config

	function automatic logic f_run(input rstpin_pkg::rstpin_state_e s);
		return (s == rstpin_pkg::RSTPIN_RUN);
	endfunction : f_run

	// Reset pin may move at any time, so it is sampled twice first
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			por_s1_q <= 1'b0;
			por_s2_q <= 1'b0;
			por_s3_q <= 1'b0;
		end else if (CE) begin
			por_s1_q <= POWER_ON_RESET_N;
			por_s2_q <= por_s1_q;
			por_s3_q <= por_s2_q;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			park_s1_q <= 1'b0;
			park_s2_q <= 1'b0;
		end else if (CE) begin
			park_s1_q <= FAST_PARK_REQUEST_N;
			park_s2_q <= park_s1_q;
		end
	end

	// Edge seen only on synchronised copies
	assign release_edge = por_s2_q & ~por_s3_q;

	// ==================================================================
	// Sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			rstpin_pkg::RSTPIN_HELD: begin
				if (release_edge) begin
					state_d = rstpin_pkg::RSTPIN_CONFIG;
				end
			end
			rstpin_pkg::RSTPIN_CONFIG: begin
				if (cnt_q == rstpin_pkg::CFG_CYCLES) begin
					state_d = rstpin_pkg::RSTPIN_RUN;
				end
			end
			rstpin_pkg::RSTPIN_RUN: begin
				state_d = rstpin_pkg::RSTPIN_RUN;
			end
			default: begin
				state_d = rstpin_pkg::RSTPIN_HELD;
			end
		endcase
		// Reassertion always wins and drops back to the safe state
		if (!por_s2_q) begin
			state_d = rstpin_pkg::RSTPIN_HELD;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_q <= rstpin_pkg::RSTPIN_HELD;
		end else if (CE) begin
			state_q <= state_d;
		end
	end

	// Counter restarts whenever configuration is left or entered again
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cnt_q <= 8'h00;
		end else if (CE) begin
			if (state_q == rstpin_pkg::RSTPIN_CONFIG) begin
				cnt_q <= cnt_q + 8'h01;
			end else begin
				cnt_q <= 8'h00;
			end
		end
	end

	// ==================================================================
	// Pin safing
	always_comb begin
		pins_d = '0;
		pins_d.flash_select_0_n = 1'b1;
		pins_d.flash_select_1_n = 1'b1;
		pins_d.gpio_oe  = rstpin_pkg::GPIO_OE_RST;
		pins_d.gpio_out = rstpin_pkg::GPIO_OUT_RST;
		pins_d.flash_oe = 1'b0;
		pins_d.light_source_select_0 = 1'b0;
		pins_d.light_source_select_1 = 1'b0;
		pins_d.mirror_array_enable_reset_n = 1'b0;
		if (!f_held(state_d)) begin
			pins_d.flash_oe           = 1'b1;
			pins_d.flash_serial_clock = CORE_FLASH_CLK;
			pins_d.flash_serial_out   = CORE_FLASH_OUT;
			pins_d.flash_select_0_n   = CORE_FLASH_SEL0_N;
			pins_d.flash_select_1_n   = CORE_FLASH_SEL1_N;
			pins_d.gpio_out = CORE_GPIO_OUT;
			pins_d.gpio_oe  = CORE_GPIO_OE;
		end
		// Light and mirror drive wait for the end of configuration
		if (f_run(state_d)) begin
			pins_d.light_source_select_0 = CORE_LIGHT_SEL0;
			pins_d.light_source_select_1 = CORE_LIGHT_SEL1;
			pins_d.mirror_array_enable_reset_n = CORE_MIRROR_EN_N;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pins_q <= '{flash_select_0_n: 1'b1, flash_select_1_n: 1'b1,
				default: '0};
		end else if (CE) begin
			pins_q <= pins_d;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			CONFIG_START <= 1'b0;
		end else if (CE) begin
			CONFIG_START <= release_edge & f_held(state_q);
		end
	end

	// ==================================================================
	// Status
	// Levels are registered from the next state so they line up with pins
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (CE) begin
			busy_q <= f_config(state_d);
			done_q <= f_run(state_d);
		end
	end

	// Park status is masked while held: no output may look active then
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			park_active_q <= 1'b0;
		end else if (CE) begin
			park_active_q <= ~park_s2_q & ~f_held(state_d);
		end
	end

	// ==================================================================
	// Pin and status outputs
	assign FLASH_SERIAL_CLOCK          = pins_q.flash_serial_clock;
	assign FLASH_SERIAL_OUT            = pins_q.flash_serial_out;
	assign FLASH_SELECT_0_N            = pins_q.flash_select_0_n;
	assign FLASH_SELECT_1_N            = pins_q.flash_select_1_n;
	assign FLASH_OE                    = pins_q.flash_oe;
	assign GPIO_OUT                    = pins_q.gpio_out;
	assign GPIO_OE                     = pins_q.gpio_oe;
	assign LIGHT_SOURCE_SELECT_0       = pins_q.light_source_select_0;
	assign LIGHT_SOURCE_SELECT_1       = pins_q.light_source_select_1;
	assign MIRROR_ARRAY_ENABLE_RESET_N = pins_q.mirror_array_enable_reset_n;
	assign CONFIG_BUSY = busy_q;
	assign CONFIG_DONE = done_q;
	assign PARK_ACTIVE = park_active_q;
endmodule : rstpin_top

// ==== verilog/rstpin_pkg.sv ====
// Package of constants and types for the power-on reset pin logic
// Contract
// - Self-configuration starts on a rising edge of the reset input.
// - Flash clock, data, both selects and twenty general pins float in reset.
// - Light-source selects and mirror enable/reset are driven low in reset.
// - No output is in its active state while reset is held.
// - After release, configuration may turn unused two-way pins into outputs.
package rstpin_pkg;
	// ==================================================================
	// Sizes and reset values
	localparam int               GPIO_W       = 20;
	localparam logic [19:0]      GPIO_OE_RST  = 20'h0_0000;
	localparam logic [19:0]      GPIO_OUT_RST = 20'h0_0000;
	localparam int               CFG_CYC_W    = 8;
	// Length of the self-configuration phase, arbitrary short figure
	localparam logic [7:0]       CFG_CYCLES   = 8'h20;

	// ==================================================================
	// Sequencer states
	typedef enum logic [1:0] {
		RSTPIN_HELD  = 2'b00,
		RSTPIN_CONFIG = 2'b01,
		RSTPIN_RUN   = 2'b10
	} rstpin_state_e;

	// ==================================================================
	// Output pins as one bundle
	typedef struct packed {
		logic              flash_serial_clock;
		logic              flash_serial_out;
		logic              flash_select_0_n;
		logic              flash_select_1_n;
		logic              flash_oe;
		logic [19:0]       gpio_out;
		logic [19:0]       gpio_oe;
		logic              light_source_select_0;
		logic              light_source_select_1;
		logic              mirror_array_enable_reset_n;
	} rstpin_pins_s;
endpackage : rstpin_pkg

// ==== tb/rstpin_top_properties.sv ====
// Concurrent checks of the power-on reset pin logic
module rstpin_checker (
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic        POWER_ON_RESET_N,
	input wire logic        CONFIG_START,
	input wire logic        CONFIG_BUSY,
	input wire logic        CONFIG_DONE,
	input wire logic        FLASH_OE,
	input wire logic        FLASH_SELECT_0_N,
	input wire logic        FLASH_SELECT_1_N,
	input wire logic        LIGHT_SOURCE_SELECT_0,
	input wire logic        LIGHT_SOURCE_SELECT_1,
	input wire logic        MIRROR_ARRAY_ENABLE_RESET_N,
	input wire logic        PARK_ACTIVE,
	input wire logic [19:0] GPIO_OE,
	input wire logic [19:0] CORE_GPIO_OE
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==================================================================
	// Pin held low needs three synced edges before outputs are safe
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	property p_start;
		$rose(POWER_ON_RESET_N) |-> !CONFIG_START[*3] ##1 CONFIG_START;
	endproperty
	a_start: assert property (p_start)
		else $error("config start not three cycles after release");
	property p_float;
		!POWER_ON_RESET_N[*4] |-> !FLASH_OE && GPIO_OE == 20'h0_0000;
	endproperty
	a_float: assert property (p_float)
		else $error("pins driven while reset held");
	property p_low;
		!POWER_ON_RESET_N[*4] |-> !(LIGHT_SOURCE_SELECT_0 |
			LIGHT_SOURCE_SELECT_1 | MIRROR_ARRAY_ENABLE_RESET_N);
	endproperty
	a_low: assert property (p_low)
		else $error("light or mirror line high while reset held");
	property p_idle;
		!POWER_ON_RESET_N[*4] |-> FLASH_SELECT_0_N && FLASH_SELECT_1_N &&
			!CONFIG_BUSY && !CONFIG_DONE;
	endproperty
	a_idle: assert property (p_idle)
		else $error("active output while reset held");
	property p_drive;
		CONFIG_START |-> FLASH_OE && GPIO_OE == $past(CORE_GPIO_OE);
	endproperty
	a_drive: assert property (p_drive)
		else $error("pin enables not taken from core at start");
	property p_done;
		CONFIG_START |-> (CONFIG_BUSY && !CONFIG_DONE)[*8] ##[25:27]
			CONFIG_DONE;
	endproperty
	a_done: assert property (p_done)
		else $error("configuration length wrong");
	property p_park;
		!POWER_ON_RESET_N[*4] |-> !PARK_ACTIVE;
	endproperty
	a_park: assert property (p_park)
		else $error("park status shown while reset held");
endmodule : rstpin_checker

bind rstpin_top rstpin_checker rstpin_checker_i (.CLK, .RST_B,
	.POWER_ON_RESET_N, .CONFIG_START, .CONFIG_BUSY, .CONFIG_DONE, .FLASH_OE,
	.FLASH_SELECT_0_N, .FLASH_SELECT_1_N, .LIGHT_SOURCE_SELECT_0,
	.LIGHT_SOURCE_SELECT_1, .MIRROR_ARRAY_ENABLE_RESET_N, .PARK_ACTIVE,
	.GPIO_OE, .CORE_GPIO_OE);

// ==== tb/rstpin_host_model.sv ====
// Host and power controller model driving the reset and park pins
module rstpin_host_model (
	input wire logic CLK,
	input wire logic go,
	output logic     por_n = 1'b0,
	output logic     park_n = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// Strap held low, and no I2C issued, so no wait is due
	always @(negedge CLK) begin
		park_n <= go;
		por_n  <= go && park_n; // clock already running
	end
endmodule : rstpin_host_model

// ==== tb/rstpin_top_tb.sv ====
// Self-checking bench for the power-on reset pin logic
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
	num_errors++; $display("unexpected %s exp %h got %h", n, e, a); end end
module rstpin_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ==================================================================
	// Signals and instances
	logic        CLK = 1'b0;
	logic        RST_B = 1'b0;
	logic        CE = 1'b1;
	logic        go = 1'b0;
	logic        por_n, park_n, FLASH_SERIAL_CLOCK, FLASH_SERIAL_OUT;
	logic        FLASH_OE, FLASH_SELECT_0_N, FLASH_SELECT_1_N, PARK_ACTIVE;
	logic        CONFIG_START, CONFIG_BUSY, CONFIG_DONE;
	logic        LIGHT_SOURCE_SELECT_0, LIGHT_SOURCE_SELECT_1;
	logic        MIRROR_ARRAY_ENABLE_RESET_N;
	logic [19:0] GPIO_OUT, GPIO_OE;
	logic [19:0] c_gpio = 20'h5_A5A5;
	logic [19:0] c_oe = 20'hF_0F0F;
	logic [6:0]  c_pin = 7'h7F;
	logic [6:0]  pin_seen;
	int          num_errors = 0;
	int          num_checks = 0;
	int          n;
	assign pin_seen = {FLASH_SERIAL_CLOCK, FLASH_SERIAL_OUT, FLASH_SELECT_0_N,
		FLASH_SELECT_1_N, LIGHT_SOURCE_SELECT_0, LIGHT_SOURCE_SELECT_1,
		MIRROR_ARRAY_ENABLE_RESET_N};
	rstpin_top rstpin_top_i (.CLK, .RST_B, .CE, .POWER_ON_RESET_N(por_n),
		.FAST_PARK_REQUEST_N(park_n), .CORE_GPIO_OUT(c_gpio),
		.CORE_GPIO_OE(c_oe), .CORE_FLASH_CLK(c_pin[6]),
		.CORE_FLASH_OUT(c_pin[5]), .CORE_FLASH_SEL0_N(c_pin[4]),
		.CORE_FLASH_SEL1_N(c_pin[3]), .CORE_LIGHT_SEL0(c_pin[2]),
		.CORE_LIGHT_SEL1(c_pin[1]), .CORE_MIRROR_EN_N(c_pin[0]),
		.FLASH_SERIAL_CLOCK, .FLASH_SERIAL_OUT, .FLASH_SELECT_0_N,
		.FLASH_SELECT_1_N, .FLASH_OE, .GPIO_OUT, .GPIO_OE,
		.LIGHT_SOURCE_SELECT_0, .LIGHT_SOURCE_SELECT_1,
		.MIRROR_ARRAY_ENABLE_RESET_N, .CONFIG_START, .CONFIG_BUSY,
		.CONFIG_DONE, .PARK_ACTIVE);
	rstpin_host_model rstpin_host_model_i (.CLK, .go, .por_n, .park_n);
	// ==================================================================
	// Scenarios
	task t_held;
		repeat (4) @(negedge CLK);
		`CHK("oe", 21'h0, {FLASH_OE, GPIO_OE})
		`CHK("sel", 2'h3, {FLASH_SELECT_0_N, FLASH_SELECT_1_N})
		`CHK("light", 3'h0, pin_seen[2:0])
		`CHK("busy", 2'h0, {CONFIG_BUSY, CONFIG_DONE})
		`CHK("park", 1'h0, PARK_ACTIVE)
	endtask : t_held
	task t_release(input logic [6:0] pins);
		c_pin = pins;
		go <= 1'b1;
		wait (por_n === 1'b1);
		n = 0;
		while (CONFIG_START !== 1'b1 && n < 9) begin
			@(negedge CLK);
			n++;
		end
		`CHK("start", 3, n)
		`CHK("oe", {1'b1, c_oe}, {FLASH_OE, GPIO_OE})
		`CHK("busy", 2'h2, {CONFIG_BUSY, CONFIG_DONE})
		`CHK("light", 3'h0, pin_seen[2:0])
		@(negedge CLK);
		n++;
		`CHK("pulse", 1'h0, CONFIG_START)
		while (CONFIG_DONE !== 1'b1 && n < 60) begin
			@(negedge CLK);
			n++;
		end
		`CHK("done", rstpin_pkg::CFG_CYCLES + 4, n)
		@(negedge CLK);
		`CHK("pins", pins, pin_seen)
		`CHK("gpio", c_gpio, GPIO_OUT)
		`CHK("park", 1'h0, PARK_ACTIVE)
	endtask : t_release
	// Clock enable low must hold every output although the core moves
	task t_freeze(input logic [6:0] pins);
		logic [6:0] old;
		old = c_pin;
		CE = 1'b0;
		c_pin = pins;
		repeat (3) @(negedge CLK);
		`CHK("frozen", old, pin_seen)
		CE = 1'b1;
		@(negedge CLK);
		`CHK("thawed", pins, pin_seen)
	endtask : t_freeze
	task wrap_up;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	initial forever #25 CLK = ~CLK;
	initial begin
		#50000;
		num_errors++;
		wrap_up;
	end
	// Second release restarts configuration after a mid-run drop
	initial begin
		repeat (5) @(negedge CLK);
		RST_B = 1'b1;
		t_held;
		t_release(7'h7F);
		t_freeze(7'h15);
		go <= 1'b0;
		wait (por_n === 1'b0);
		t_held;
		t_release(7'h2A);
		wrap_up;
	end
endmodule : rstpin_top_tb
